// [hdl/phy_regs_pkg.sv]
// Purpose: Shared constants for the port control/status registers
// Assumes: Management frames of the usual two-wire form
// Notes:   Register addresses are the 5-bit register field of a frame
package phy_regs_pkg;
    // Register addresses
    localparam logic [4:0]  ADDR_CONTROL     = 5'h00;
    localparam logic [4:0]  ADDR_STATUS      = 5'h01;
    // Control field positions
    localparam int          CTL_LOOPBACK     = 14;
    localparam int          CTL_SPEED_100    = 13;
    localparam int          CTL_AN_ENABLE    = 12;
    localparam int          CTL_AN_RESTART   = 9;
    localparam int          CTL_FULL_DUPLEX  = 8;
    // Status field positions
    localparam int          STS_T4_ABLE      = 15;
    localparam int          STS_AN_COMPLETE  = 5;
    localparam int          STS_REMOTE_FAULT = 4;
    localparam int          STS_LINK_UP      = 2;
    // Values after reset
    localparam logic [15:0] CONTROL_RESET    = 16'h3000;
    // Fixed status bits: 100X FD/HD, 10T FD/HD, preamble suppression, AN ability
    localparam logic [15:0] STATUS_FIXED     = 16'h7848;
    // Port whose auto-negotiation is locked off in fiber mode with signal detect
    localparam int          FIBER_PORT_INDEX = 4;
    // Management frame fields
    localparam logic [1:0]  OP_READ          = 2'b10;
    localparam logic [1:0]  OP_WRITE         = 2'b01;
    localparam logic [4:0]  HEAD_LAST        = 5'h0C;
    localparam logic [4:0]  DATA_LAST        = 5'h0F;
endpackage : phy_regs_pkg

// [hdl/smi_target.sv]
// Purpose: Management frame receiver/transmitter for register access
// Assumes: MDC at most a quarter of CLK; PHY address from the top
// Notes:   Preamble may be suppressed; start is a 0 followed by 1
`timescale 1ns/1ps
module smi_target
    import phy_regs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [15:0] rd_data,
    output logic             mdio_o,
    output logic             mdio_oe,
    output logic [4:0]       reg_addr,
    output logic             wr_pulse,
    output logic [15:0]      wr_data
);
    typedef enum logic [1:0] {IDLE, HEAD, TURN, DATA} smi_e;

    typedef struct packed {
        logic        mdc_s1;
        logic        mdc_s2;
        logic        mdc_s3;
        logic        md_s1;
        logic        md_s2;
        smi_e        st;
        logic        prev_bit;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        is_read;
        logic        sel;
        logic        o;
        logic        oe;
        logic [4:0]  addr;
        logic        wr;
        logic [15:0] wdata;
    } smi_s;

    smi_s s_q, s_d;
    logic rise;
    logic bit_in;
    logic [15:0] sh_in;

    assign rise   = s_q.mdc_s2 & ~s_q.mdc_s3;
    assign bit_in = s_q.md_s2;
    assign sh_in  = {s_q.sh[14:0], bit_in};

    always_comb begin
        s_d        = s_q;
        s_d.mdc_s1 = mdc;
        s_d.mdc_s2 = s_q.mdc_s1;
        s_d.mdc_s3 = s_q.mdc_s2;
        s_d.md_s1  = mdio_i;
        s_d.md_s2  = s_q.md_s1;
        s_d.wr     = 1'b0;
        if (rise) begin
            case (s_q.st)
                IDLE: begin
                    s_d.prev_bit = bit_in;
                    if (s_q.prev_bit && !bit_in) begin
                        s_d.st  = HEAD;
                        s_d.cnt = 5'h00;
                    end
                end
                HEAD: begin
                    s_d.sh  = sh_in;
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == HEAD_LAST) begin
                        s_d.cnt     = 5'h00;
                        s_d.addr    = sh_in[4:0];
                        s_d.sel     = (sh_in[9:5] == phy_addr);
                        s_d.is_read = (sh_in[11:10] == OP_READ);
                        s_d.prev_bit = 1'b0;
                        if (!sh_in[12] ||
                            (sh_in[11:10] != OP_READ && sh_in[11:10] != OP_WRITE)) begin
                            s_d.st = IDLE;
                        end else begin
                            s_d.st = TURN;
                        end
                    end
                end
                TURN: begin
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == 5'h00) begin
                        s_d.sh = rd_data;
                        if (s_q.is_read && s_q.sel) begin
                            s_d.oe = 1'b1;
                            s_d.o  = 1'b0;
                        end
                    end else begin
                        s_d.st  = DATA;
                        s_d.cnt = 5'h00;
                        s_d.o   = s_q.sh[15];
                    end
                end
                DATA: begin
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.is_read) begin
                        s_d.sh = {s_q.sh[14:0], 1'b0};
                        s_d.o  = s_q.sh[14];
                    end else begin
                        s_d.sh = sh_in;
                    end
                    if (s_q.cnt == DATA_LAST) begin
                        s_d.st    = IDLE;
                        s_d.oe    = 1'b0;
                        s_d.o     = 1'b0;
                        s_d.wr    = ~s_q.is_read & s_q.sel;
                        s_d.wdata = sh_in;
                    end
                end
                default: s_d.st = IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign mdio_o   = s_q.o;
    assign mdio_oe  = s_q.oe;
    assign reg_addr = s_q.addr;
    assign wr_pulse = s_q.wr;
    assign wr_data  = s_q.wdata;
endmodule : smi_target

// [hdl/phy_mii_control_status_regs.sv]
// Purpose: Port control register and status register with loopback path
// Assumes: MII and negotiation engine signals share CLK; straps are pins
// Notes:   Registers reached only through management frames
// Operation
// (R1) Loopback set: MII transmit enable sends nothing to the line.
// (R2) Loopback set: MII transmit data returns on MII receive path.
// (R3) Forced speed and duplex bits apply only with negotiation disabled.
// (R4) Fiber port 4 with signal detect: negotiation enable reads 0, ignores writes.
// (R5) Writing restart 1 starts negotiation when negotiation is enabled.
// (R6) Negotiation disabled: restart bit is read-only, writes do nothing.
// (R7) Restart reads 1 while pending, clears when negotiation completes.
// (R8) Host writes zero to control bits 6..0, ignores their read value.
// (R9) Status bit 15, T4 capability, always reads 0.
// (R10) Reset, power down, isolate, collision test read 0, ignore writes.
// (R11) Negotiation complete status reads 0 while negotiation disabled.
`timescale 1ns/1ps
module phy_mii_control_status_regs
    import phy_regs_pkg::*;
#(
    parameter int         PORT_INDEX = 4,
    parameter logic [4:0] PHY_ADDR   = 5'h04
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       MDC,
    input  wire logic       MDIO_I,
    output logic            MDIO_O,
    output logic            MDIO_OE,
    input  wire logic       FIBER_MODE,
    input  wire logic       FIBER_SIGNAL_DETECT,
    input  wire logic       MII_TXEN,
    input  wire logic [3:0] MII_TXD,
    output logic            MII_RXDV,
    output logic [3:0]      MII_RXD,
    output logic            LINE_TXEN,
    output logic [3:0]      LINE_TXD,
    input  wire logic       LINE_RXDV,
    input  wire logic [3:0] LINE_RXD,
    input  wire logic       AN_CYCLE_DONE,
    input  wire logic       AN_COMPLETE,
    input  wire logic       AN_SPEED_100,
    input  wire logic       AN_FULL_DUPLEX,
    input  wire logic       LINK_UP,
    input  wire logic       REMOTE_FAULT,
    output logic            AN_ENABLE,
    output logic            AN_RESTART,
    output logic            LINK_SPEED_100,
    output logic            LINK_FULL_DUPLEX
);
    typedef struct packed {
        logic       loop;
        logic       speed;
        logic       an_en;
        logic       restart;
        logic       duplex;
        logic       fib_s1;
        logic       fib_s2;
        logic       sd_s1;
        logic       sd_s2;
        logic       an_enable;
        logic       an_restart;
        logic       spd_out;
        logic       dup_out;
        logic       rxdv;
        logic [3:0] rxd;
        logic       ltxen;
        logic [3:0] ltxd;
    } regs_s;

    regs_s s_q, s_d;
    logic [4:0]  acc_addr;
    logic        wr;
    logic [15:0] wdata;
    logic [15:0] rd_data;
    logic [15:0] ctl_word;
    logic [15:0] sts_word;
    logic        an_locked;
    logic        an_eff;
    logic        an_en_new;
    logic        ctl_wr;
    logic        restart_wr;

    smi_target u_smi (
        .clk      (CLK),
        .rst      (RST),
        .mdc      (MDC),
        .mdio_i   (MDIO_I),
        .phy_addr (PHY_ADDR),
        .rd_data  (rd_data),
        .mdio_o   (MDIO_O),
        .mdio_oe  (MDIO_OE),
        .reg_addr (acc_addr),
        .wr_pulse (wr),
        .wr_data  (wdata)
    );

    // Fiber lock of negotiation enable
    assign an_locked  = (PORT_INDEX == FIBER_PORT_INDEX) & s_q.fib_s2 & s_q.sd_s2; // R4
    assign an_eff     = s_q.an_en & ~an_locked; // R4
    assign ctl_wr     = wr && (acc_addr == ADDR_CONTROL);
    assign an_en_new  = (an_locked ? s_q.an_en : wdata[CTL_AN_ENABLE]) & ~an_locked; // R4
    assign restart_wr = ctl_wr && wdata[CTL_AN_RESTART] && an_en_new; // R5 R6

    // Read views; unimplemented and reserved bits read 0
    always_comb begin
        ctl_word                  = 16'h0000; // R10
        ctl_word[CTL_LOOPBACK]    = s_q.loop;
        ctl_word[CTL_SPEED_100]   = s_q.speed;
        ctl_word[CTL_AN_ENABLE]   = an_eff; // R4
        ctl_word[CTL_AN_RESTART]  = s_q.restart; // R7
        ctl_word[CTL_FULL_DUPLEX] = s_q.duplex;
        sts_word                   = STATUS_FIXED;
        sts_word[STS_T4_ABLE]      = 1'b0; // R9
        sts_word[STS_AN_COMPLETE]  = AN_COMPLETE & an_eff; // R11
        sts_word[STS_REMOTE_FAULT] = REMOTE_FAULT;
        sts_word[STS_LINK_UP]      = LINK_UP;
        case (acc_addr)
            ADDR_CONTROL: rd_data = ctl_word;
            ADDR_STATUS:  rd_data = sts_word;
            default:      rd_data = 16'h0000;
        endcase
    end

    always_comb begin
        s_d        = s_q;
        s_d.fib_s1 = FIBER_MODE;
        s_d.fib_s2 = s_q.fib_s1;
        s_d.sd_s1  = FIBER_SIGNAL_DETECT;
        s_d.sd_s2  = s_q.sd_s1;
        if (ctl_wr) begin
            // Bits 15, 11, 10, 7 and 6..0 are not stored
            s_d.loop   = wdata[CTL_LOOPBACK]; // R10
            s_d.speed  = wdata[CTL_SPEED_100];
            s_d.duplex = wdata[CTL_FULL_DUPLEX];
            if (!an_locked) begin
                s_d.an_en = wdata[CTL_AN_ENABLE]; // R4
            end
        end
        // Restart: completion clears, a new request wins
        if (s_q.restart && AN_CYCLE_DONE) begin
            s_d.restart = 1'b0; // R7
        end
        if (!an_eff) begin
            s_d.restart = 1'b0; // R6
        end
        if (restart_wr) begin
            s_d.restart = 1'b1; // R5
        end
        s_d.an_restart = restart_wr; // R5
        s_d.an_enable  = an_eff;
        s_d.spd_out    = an_eff ? AN_SPEED_100 : s_q.speed; // R3
        s_d.dup_out    = an_eff ? AN_FULL_DUPLEX : s_q.duplex; // R3
        // Loopback path
        s_d.ltxen = MII_TXEN & ~s_q.loop; // R1
        s_d.ltxd  = s_q.loop ? 4'h0 : MII_TXD; // R1
        s_d.rxdv  = s_q.loop ? MII_TXEN : LINE_RXDV; // R2
        s_d.rxd   = s_q.loop ? MII_TXD : LINE_RXD; // R2
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q         <= '0;
            s_q.speed   <= CONTROL_RESET[CTL_SPEED_100];
            s_q.an_en   <= CONTROL_RESET[CTL_AN_ENABLE];
            s_q.spd_out <= CONTROL_RESET[CTL_SPEED_100];
        end else begin
            s_q <= s_d;
        end
    end

    assign AN_ENABLE        = s_q.an_enable;
    assign AN_RESTART       = s_q.an_restart;
    assign LINK_SPEED_100   = s_q.spd_out;
    assign LINK_FULL_DUPLEX = s_q.dup_out;
    assign MII_RXDV         = s_q.rxdv;
    assign MII_RXD          = s_q.rxd;
    assign LINE_TXEN        = s_q.ltxen;
    assign LINE_TXD         = s_q.ltxd;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_loop_isolates: assert property (s_q.loop |=> !LINE_TXEN) // R1
        else $error("line transmit active in loopback");
    chk_loop_returns: assert property (s_q.loop && MII_TXEN |=> // R2
        MII_RXDV && MII_RXD == $past(MII_TXD))
        else $error("loopback data not returned");
    chk_forced_mode: assert property (!an_eff |=> // R3
        LINK_SPEED_100 == $past(s_q.speed) && LINK_FULL_DUPLEX == $past(s_q.duplex))
        else $error("forced speed or duplex not applied");
    chk_fiber_an_off: assert property (an_locked |-> !ctl_word[CTL_AN_ENABLE] && !AN_RESTART) // R4
        else $error("negotiation enabled on locked fiber port");
    chk_restart_start: assert property (restart_wr |=> AN_RESTART && ctl_word[CTL_AN_RESTART]) // R5
        else $error("restart write did not start negotiation");
    chk_restart_ro: assert property (ctl_wr && !an_en_new && !s_q.restart |=> // R6
        !s_q.restart && !AN_RESTART)
        else $error("restart written while negotiation disabled");
    chk_restart_clear: assert property (s_q.restart && AN_CYCLE_DONE && !restart_wr |=> // R7
        !ctl_word[CTL_AN_RESTART])
        else $error("restart not cleared on completion");
    chk_t4_zero: assert property (sts_word[STS_T4_ABLE] == 1'b0) // R9
        else $error("T4 capability reads 1");
    chk_unimpl_zero: assert property (ctl_wr |=> // R10
        ctl_word[15] == 1'b0 && ctl_word[11:10] == 2'b00 && ctl_word[7:0] == 8'h00)
        else $error("unimplemented control bit reads 1");
    chk_an_done_gate: assert property (!an_eff |-> !sts_word[STS_AN_COMPLETE]) // R11
        else $error("negotiation complete shown while disabled");
    chk_t4_on_read: assert property (acc_addr == ADDR_STATUS |-> !rd_data[STS_T4_ABLE]) // R9
        else $error("T4 capability served on status read");
    chk_restart_single: assert property (AN_RESTART |=> !AN_RESTART) // R5
        else $error("restart pulse longer than one cycle");
    chk_lock_out_off: assert property (an_locked |=> !AN_ENABLE) // R4
        else $error("negotiation enable output high on locked fiber port");
    chk_done_read_gate: assert property (!an_eff && acc_addr == ADDR_STATUS |-> // R11
        !rd_data[STS_AN_COMPLETE])
        else $error("negotiation complete served while disabled");

    cov_loop_frame: cover property (s_q.loop && MII_TXEN ##1 MII_RXDV ##1 MII_RXDV);
    cov_restart_done: cover property (restart_wr ##[1:1000] (s_q.restart && AN_CYCLE_DONE));
    cov_fiber_lock: cover property (ctl_wr && wdata[CTL_AN_ENABLE] && an_locked);
    cov_status_read: cover property (MDIO_OE && acc_addr == ADDR_STATUS);
endmodule : phy_mii_control_status_regs

// [tb/smi_host.sv]
// Purpose: Management host model driving frames on MDC and MDIO
// Assumes: Line is pulled up while nobody drives it
// Notes:   MDC period is eight CLK cycles; data is sampled at MDC rise
`timescale 1ns/1ps
module smi_host
    import phy_regs_pkg::*;
(
    input  wire logic clk,
    input  wire logic mdio,
    output logic      mdc,
    output logic      drv,
    output logic      en
);
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        en  = 1'b0;
    end

    // One MDC period: drive or release, then sample at the rise
    task automatic bit_io(input logic e, input logic b, output logic s);
        @(posedge clk);
        mdc <= 1'b0;
        en  <= e;
        drv <= b;
        repeat (4) @(posedge clk);
        mdc <= 1'b1;
        s = mdio;
        repeat (3) @(posedge clk);
    endtask : bit_io

    // Whole frame; reads release the line from the turnaround on
    task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [33:0] f;
        logic        s;
        q = 16'h0000;
        f = {4'hD, rd ? OP_READ : OP_WRITE, phy, ra, 2'b10, wd & 16'hFF80};
        for (int i = 33; i >= 0; i--) begin
            bit_io(!rd || i > 17, f[i], s);
            if (rd && i < 16) q[i] = s;
        end
        bit_io(1'b0, 1'b1, s);
    endtask : frame
endmodule : smi_host

// [tb/testbench.sv]
// Purpose: Self-checking bench for the port control and status registers
// Assumes: Seeded random register values with corner cases first
// Notes:   MII traffic runs all the time and is checked between frames
`timescale 1ns/1ps
module testbench;
    import phy_regs_pkg::*;
    localparam logic [4:0] PHY_A = 5'h04;
    logic        clk, rst, mdc, drv, en, mdio, mdio_o, mdio_oe;
    logic        fm, fsd, txen, lrxdv, done, anc, aspd, afd, lnk, flt;
    logic        rxdv, ltxen, an_en, an_rs, spd, fdx, mon, lb, lock, ae;
    logic        ptxen, plrxdv;
    logic [3:0]  txd, lrxd, rxd, ltxd, ptxd, plrxd;
    logic [1:0]  r;
    logic [15:0] q, d;
    logic [15:0] cn [4] = '{16'h0200, 16'hFFFF, 16'h1200, 16'h4000};
    int          num_errors, n_tests, seed, cyc, n_rs, n0;

    assign mdio = mdio_oe ? mdio_o : (en ? drv : 1'b1);

    phy_mii_control_status_regs #(.PORT_INDEX(4), .PHY_ADDR(PHY_A)) dut_u (
        .CLK(clk), .RST(rst), .MDC(mdc), .MDIO_I(mdio), .MDIO_O(mdio_o),
        .MDIO_OE(mdio_oe), .FIBER_MODE(fm), .FIBER_SIGNAL_DETECT(fsd),
        .MII_TXEN(txen), .MII_TXD(txd), .MII_RXDV(rxdv), .MII_RXD(rxd),
        .LINE_TXEN(ltxen), .LINE_TXD(ltxd), .LINE_RXDV(lrxdv), .LINE_RXD(lrxd),
        .AN_CYCLE_DONE(done), .AN_COMPLETE(anc), .AN_SPEED_100(aspd),
        .AN_FULL_DUPLEX(afd), .LINK_UP(lnk), .REMOTE_FAULT(flt),
        .AN_ENABLE(an_en), .AN_RESTART(an_rs), .LINK_SPEED_100(spd),
        .LINK_FULL_DUPLEX(fdx));

    smi_host host_u (.clk(clk), .mdio(mdio), .mdc(mdc), .drv(drv), .en(en));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    function automatic logic [15:0] exp_ctl(input logic [15:0] v, input logic a);
        return (v & 16'h6100) | {3'h0, a, 2'h0, a & v[9], 9'h000};
    endfunction : exp_ctl

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // MII traffic, pulse counting, loopback monitor and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        {txen, txd, lrxdv, lrxd} <= 10'($random(seed));
        {ptxen, ptxd, plrxdv, plrxd} <= {txen, txd, lrxdv, lrxd};
        if (an_rs === 1'b1) n_rs <= n_rs + 1;
        if (mon) begin
            chk("line tx", lb ? 16'h0000 : {11'h0, ptxen, ptxd}, {11'h0, ltxen, ltxd});
            if (lb) chk("loop rx", {11'h0, ptxen, ptxd}, {11'h0, rxdv, rxd});
            if (!lb) chk("line rx", {11'h0, plrxdv, plrxd}, {11'h0, rxdv, rxd});
        end
        if (cyc == 40000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        {rst, fm, fsd, done, anc, aspd, afd, lnk, flt, mon, lb} = 11'h400;
        {txen, txd, lrxdv, lrxd} = 10'h000;
        {ptxen, ptxd, plrxdv, plrxd} = 10'h000;
        {num_errors, n_tests, cyc, n_rs} = '0;
        seed = 32'hCD51;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        host_u.frame(PHY_A, 1'b1, ADDR_CONTROL, 16'h0000, q);
        chk("ctl reset", CONTROL_RESET, q);
        for (int k = 0; k < 14; k++) begin
            @(posedge clk);
            d = k < 4 ? cn[k] : 16'($random(seed));
            r = k < 4 ? 2'b00 : 2'($random(seed));
            lock = &r;
            ae = d[12] & !lock;
            fm <= r[1];
            fsd <= r[0];
            {anc, aspd, afd, lnk, flt} <= 5'($random(seed));
            mon <= 1'b0;
            n0 = n_rs;
            host_u.frame(PHY_A, 1'b0, ADDR_CONTROL, d, q);
            repeat (6) @(posedge clk);
            lb = d[14];
            chk("restart pulse", 16'(ae & d[9]), 16'(n_rs - n0));
            chk("an enable", 16'(ae), 16'(an_en));
            chk("speed", 16'(ae ? aspd : d[13]), 16'(spd));
            chk("duplex", 16'(ae ? afd : d[8]), 16'(fdx));
            host_u.frame(PHY_A, 1'b1, ADDR_CONTROL, 16'h0000, q);
            chk("ctl read", exp_ctl(d, ae), q);
            host_u.frame(PHY_A, 1'b1, ADDR_STATUS, 16'h0000, q);
            chk("status", (STATUS_FIXED & 16'h7FFF) | {10'h0, ae & anc, flt, 1'b0, lnk, 2'h0}, q);
            @(posedge clk);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            host_u.frame(PHY_A, 1'b1, ADDR_CONTROL, 16'h0000, q);
            chk("ctl after done", exp_ctl(d, ae) & 16'hFDFF, q);
            mon <= 1'b1;
            repeat (20) @(posedge clk);
            $display("test %0d done, data %h", k, d);
        end
        mon <= 1'b0;
        host_u.frame(PHY_A ^ 5'h01, 1'b1, ADDR_CONTROL, 16'h0000, q);
        chk("other phy", 16'hFFFF, q);
        host_u.frame(PHY_A, 1'b1, 5'h1F, 16'h0000, q);
        chk("unmapped", 16'h0000, q);
        $display("test address refusal done");
        close_out();
    end
endmodule : testbench
